/* File: src/cfs_supervisor.sv */
/*
 * Fault supervisor and mode control for a high-speed bus transceiver.
 * Assumes a host on the plain register port and on the transmit and
 * receive pins, and analog detectors that deliver asynchronous levels.
 */
// Local design decisions: the register addresses and the strobed register port.
// Notes on behaviour
// - Detect the transmit input shorted to the receive output.
// - Record that short in the readable fault flags.
// - Pull the interrupt low on that short unless masked.
// - Inhibit the transmitter on that short until a release command.
// - Overtemperature turns the driver stages off.
// - After cooling, recover alone and keep the selected mode.
// - After cooling, transmit only after a dominant-to-recessive transmit edge.
// - Receive stuck recessive during traffic disables the transmitter meanwhile.
// - After receive clamping, transmit again only after a release command.
// - No own undervoltage detector; supply monitor is reported, host decides.
// - Detect each bus line short to ground, battery or logic supply.
// - Any bus line short sets the bus flag and interrupts unless masked.
// - Bus line shorts never change the transceiver mode.
// - Stabilizer driven in normal and receive-only, high impedance otherwise.
// - Receive-only keeps the driver off and still delivers bus data.
// - Off mode ignores wake-up activity on the bus.
`timescale 1ns/100ps
`default_nettype none

module cfs_supervisor
    import cfs_pkg::*;
#(
    parameter int SHORT_CYC = TXRX_SHORT_CYC,
    parameter int CLAMP_CYC = RX_CLAMP_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic txd_pin,
    input wire logic rxd_pin_sense,
    input wire logic bus_rx_dom,
    input wire logic bus_wake_det,
    input wire logic overtemp_det,
    input wire logic supply_uv,
    input wire logic [NSHORT-1:0] bus_short_det,
    output logic rxd_pin,
    output logic drv_en,
    output logic drv_dom,
    output logic split_out,
    output logic split_oe_n,
    output logic transceiver_supply_en,
    output logic int_n
);

    typedef struct packed {
        cfs_mode_t mode;
        logic supply_en;
        logic [NFLAG-1:0] mask;
        logic [NFLAG-1:0] flags;
        logic [NSHORT-1:0] shorts;
        cfs_ot_t ot;
        logic txrx_inh;
        logic clamp_inh;
        logic clamp_present;
        logic txd_prev;
        logic wake_prev;
        logic drv_en;
        logic drv_dom;
        logic rxd;
        logic split_oe_n;
        logic int_n;
        logic [DATA_W-1:0] rdata;
    } cfs_state_t;

    localparam int NSYNC = NSHORT + 6;
    localparam logic [NSYNC-1:0] SYNC_RST = {{NSHORT{1'b0}}, 6'h03};

    cfs_state_t st_reg;
    cfs_state_t st_next;
    logic [NSYNC-1:0] sync_q;
    logic txd_s;
    logic rxs_s;
    logic bus_dom_s;
    logic wake_s;
    logic ot_s;
    logic uv_s;
    logic [NSHORT-1:0] short_s;
    logic short_hit;
    logic clamp_hit;
    logic rx_active;

    // All asynchronous levels share one synchroniser bank.
    cfs_sync #(
        .W(NSYNC),
        .RST(SYNC_RST)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({bus_short_det, supply_uv, overtemp_det, bus_wake_det,
            bus_rx_dom, rxd_pin_sense, txd_pin}),
        .q(sync_q)
    );

    assign txd_s = sync_q[0];
    assign rxs_s = sync_q[1];
    assign bus_dom_s = sync_q[2];
    assign wake_s = sync_q[3];
    assign ot_s = sync_q[4];
    assign uv_s = sync_q[5];
    assign short_s = sync_q[NSYNC-1:6];

    assign rx_active = (st_reg.mode == CFS_MODE_NORMAL) ||
                       (st_reg.mode == CFS_MODE_RXONLY);

    // The receive pin reads low while we drive it high and the host holds
    // the transmit pin dominant: the two pins are tied together.
    cfs_filt #(
        .CNT_W(FILT_CNT_W),
        .LIMIT(SHORT_CYC)
    ) u_short (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cond(st_reg.rxd && !rxs_s && !txd_s),
        .hit(short_hit)
    );

    // We drive the receive pin dominant for bus traffic but it reads back
    // recessive: something clamps it high.
    cfs_filt #(
        .CNT_W(FILT_CNT_W),
        .LIMIT(CLAMP_CYC)
    ) u_clamp (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cond(rx_active && !st_reg.rxd && rxs_s),
        .hit(clamp_hit)
    );

    always_comb begin
        logic release_cmd;
        logic [NFLAG-1:0] set;
        logic [NFLAG-1:0] clr;
        logic [NSHORT-1:0] short_clr;
        logic tx_edge;
        release_cmd = 1'b0;
        set = '0;
        clr = '0;
        short_clr = '0;
        tx_edge = 1'b0;
        st_next = st_reg;

        // Register writes. The mode is only ever changed here.
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: begin
                    st_next.mode = cfs_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
                    st_next.supply_en = reg_wdata[CTRL_SUPPLY];
                end
                OFS_MASK: begin
                    st_next.mask = reg_wdata[NFLAG-1:0];
                end
                OFS_CMD: begin
                    release_cmd = reg_wdata[CMD_TX_RELEASE];
                end
                OFS_FLAGS: begin
                    clr = reg_wdata[NFLAG-1:0];
                end
                OFS_SHORTS: begin
                    short_clr = reg_wdata[NSHORT-1:0];
                end
                default: begin
                end
            endcase
        end

        // Reads; flag and short registers clear on read.
        st_next.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: begin
                    st_next.rdata = {5'h00, st_reg.supply_en, st_reg.mode};
                end
                OFS_MASK: begin
                    st_next.rdata = {3'h0, st_reg.mask};
                end
                OFS_FLAGS: begin
                    st_next.rdata = {3'h0, st_reg.flags};
                    clr = {NFLAG{1'b1}};
                end
                OFS_LIVE: begin
                    st_next.rdata = {2'h0, ot_s, uv_s,
                        st_reg.ot != CFS_OT_IDLE, st_reg.clamp_inh,
                        st_reg.txrx_inh, st_reg.drv_en};
                end
                OFS_SHORTS: begin
                    st_next.rdata = {2'h0, st_reg.shorts};
                    short_clr = {NSHORT{1'b1}};
                end
                default: begin
                    st_next.rdata = '0;
                end
            endcase
        end

        // Transmit-to-receive short.
        if (short_hit) begin
            set[FLG_TXRX] = 1'b1;
        end
        if (release_cmd) begin
            st_next.txrx_inh = 1'b0;
        end
        if (short_hit) begin
            st_next.txrx_inh = 1'b1;
        end

        // Receive clamping: inhibit holds while present, a release only
        // counts once the pin has been seen dominant again.
        if (!rxs_s) begin
            st_next.clamp_present = 1'b0;
        end
        if (release_cmd && !st_reg.clamp_present) begin
            st_next.clamp_inh = 1'b0;
        end
        if (clamp_hit) begin
            st_next.clamp_present = 1'b1;
            st_next.clamp_inh = 1'b1;
            set[FLG_CLAMP] = 1'b1;
        end

        // Overtemperature: no software action needed to recover.
        st_next.txd_prev = txd_s;
        tx_edge = !st_reg.txd_prev && txd_s;
        case (st_reg.ot)
            CFS_OT_IDLE: begin
                if (ot_s) begin
                    st_next.ot = CFS_OT_HOT;
                end
            end
            CFS_OT_HOT: begin
                if (!ot_s) begin
                    st_next.ot = CFS_OT_WAIT_EDGE;
                end
            end
            CFS_OT_WAIT_EDGE: begin
                if (ot_s) begin
                    st_next.ot = CFS_OT_HOT;
                end else if (tx_edge) begin
                    st_next.ot = CFS_OT_IDLE;
                end
            end
            default: begin
                st_next.ot = CFS_OT_HOT;
            end
        endcase
        if (ot_s && st_reg.ot == CFS_OT_IDLE) begin
            set[FLG_OT] = 1'b1;
        end

        // Bus line shorts only report; the mode is untouched.
        if (|short_s) begin
            set[FLG_BUS] = 1'b1;
        end
        st_next.shorts = (st_reg.shorts & ~short_clr) | short_s;

        // Wake detection only in wake-capable mode.
        st_next.wake_prev = wake_s;
        if (st_reg.mode == CFS_MODE_WAKE && wake_s && !st_reg.wake_prev) begin
            set[FLG_WAKE] = 1'b1;
        end

        // Set wins over a clear in the same cycle.
        st_next.flags = (st_reg.flags & ~clr) | set;
        st_next.int_n = ~|(st_next.flags & ~st_next.mask);

        // Driver enable needs every inhibit source idle.
        st_next.drv_en = (st_reg.mode == CFS_MODE_NORMAL) &&
            st_reg.supply_en && !st_reg.txrx_inh &&
            !st_reg.clamp_inh && st_reg.ot == CFS_OT_IDLE;
        st_next.drv_dom = st_next.drv_en && !txd_s;

        // Receive pin: bus data while receiving, low after a wake-up.
        if (rx_active) begin
            st_next.rxd = !bus_dom_s;
        end else if (st_reg.mode == CFS_MODE_WAKE) begin
            st_next.rxd = !st_reg.flags[FLG_WAKE];
        end else begin
            st_next.rxd = 1'b1;
        end

        st_next.split_oe_n = !rx_active;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{mode: CFS_MODE_OFF, supply_en: CTRL_RST[CTRL_SUPPLY],
                mask: MASK_RST, flags: '0, shorts: '0, ot: CFS_OT_IDLE,
                txrx_inh: 1'b0, clamp_inh: 1'b0, clamp_present: 1'b0,
                txd_prev: 1'b1, wake_prev: 1'b0, drv_en: 1'b0,
                drv_dom: 1'b0, rxd: 1'b1, split_oe_n: 1'b1, int_n: 1'b1,
                rdata: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign rxd_pin = st_reg.rxd;
    assign drv_en = st_reg.drv_en;
    assign drv_dom = st_reg.drv_dom;
    assign split_out = 1'b1;
    assign split_oe_n = st_reg.split_oe_n;
    assign transceiver_supply_en = st_reg.supply_en;
    assign int_n = st_reg.int_n;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_short_latch;
        short_hit |=> st_reg.flags[FLG_TXRX] && st_reg.txrx_inh;
    endproperty
    a_short_latch: assert property (p_short_latch)
        else $error("short not latched");

    property p_int_low;
        (|(st_reg.flags & ~st_reg.mask)) |-> !int_n;
    endproperty
    a_int_low: assert property (p_int_low)
        else $error("interrupt not raised");

    property p_txrx_blocks;
        st_reg.txrx_inh |=> !drv_en;
    endproperty
    a_txrx_blocks: assert property (p_txrx_blocks)
        else $error("driver on while short inhibit");

    property p_hot_off;
        st_reg.ot == CFS_OT_HOT |=> !drv_en;
    endproperty
    a_hot_off: assert property (p_hot_off)
        else $error("driver on while hot");

    sequence s_cooled;
        st_reg.ot == CFS_OT_WAIT_EDGE && !ot_s;
    endsequence
    sequence s_rise;
        !st_reg.txd_prev && txd_s;
    endsequence
    property p_edge_release;
        s_cooled and s_rise |=> st_reg.ot == CFS_OT_IDLE ##1
            drv_en == ($past(st_reg.mode) == CFS_MODE_NORMAL &&
            $past(st_reg.supply_en) && !$past(st_reg.txrx_inh) &&
            !$past(st_reg.clamp_inh));
    endproperty
    a_edge_release: assert property (p_edge_release)
        else $error("no release after cooled edge");

    property p_wait_blocks;
        st_reg.ot == CFS_OT_WAIT_EDGE |=> !drv_en;
    endproperty
    a_wait_blocks: assert property (p_wait_blocks)
        else $error("driver on before release edge");

    property p_clamp_hold;
        st_reg.clamp_present |=> !drv_en;
    endproperty
    a_clamp_hold: assert property (p_clamp_hold)
        else $error("driver on during clamp");

    property p_bus_flag;
        (|short_s) |=> st_reg.flags[FLG_BUS] && st_reg.shorts != '0;
    endproperty
    a_bus_flag: assert property (p_bus_flag)
        else $error("bus short not flagged");

    property p_mode_kept;
        !reg_wr |=> $stable(st_reg.mode);
    endproperty
    a_mode_kept: assert property (p_mode_kept)
        else $error("mode changed without a write");

    property p_split;
        rx_active |=> !split_oe_n;
    endproperty
    a_split: assert property (p_split)
        else $error("stabilizer not driven");

    property p_rxonly;
        st_reg.mode == CFS_MODE_RXONLY |=> !drv_en && !drv_dom;
    endproperty
    a_rxonly: assert property (p_rxonly)
        else $error("driver on in receive-only");

    property p_off_wake;
        st_reg.mode == CFS_MODE_OFF && !st_reg.flags[FLG_WAKE]
            |=> !st_reg.flags[FLG_WAKE];
    endproperty
    a_off_wake: assert property (p_off_wake)
        else $error("wake taken in off mode");

endmodule

`default_nettype wire

/* File: src/cfs_pkg.sv */
/*
 * Shared constants for the transceiver fault supervisor: register map,
 * field positions, reset values, mode codes and filter times.
 * Assumes a 20 MHz core clock; all counts are derived from it.
 */
package cfs_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_MASK = 4'h1;
    localparam logic [3:0] OFS_CMD = 4'h2;
    localparam logic [3:0] OFS_FLAGS = 4'h3;
    localparam logic [3:0] OFS_LIVE = 4'h4;
    localparam logic [3:0] OFS_SHORTS = 4'h5;

    // Control register fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SUPPLY = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Command register fields.
    localparam int CMD_TX_RELEASE = 0;

    // Flag positions, shared by the flag and mask registers.
    localparam int NFLAG = 5;
    localparam int FLG_TXRX = 0;
    localparam int FLG_BUS = 1;
    localparam int FLG_CLAMP = 2;
    localparam int FLG_OT = 3;
    localparam int FLG_WAKE = 4;
    localparam logic [NFLAG-1:0] MASK_RST = 5'h00;

    // Live status fields.
    localparam int LIVE_DRV = 0;
    localparam int LIVE_TXRX_INH = 1;
    localparam int LIVE_CLAMP_INH = 2;
    localparam int LIVE_OT_BLOCK = 3;
    localparam int LIVE_UV = 4;
    localparam int LIVE_OT = 5;

    // Six bus line short conditions.
    localparam int NSHORT = 6;

    typedef enum logic [1:0] {
        CFS_MODE_OFF = 2'h0,
        CFS_MODE_WAKE = 2'h1,
        CFS_MODE_RXONLY = 2'h2,
        CFS_MODE_NORMAL = 2'h3
    } cfs_mode_t;

    typedef enum logic [2:0] {
        CFS_OT_IDLE = 3'h1,
        CFS_OT_HOT = 3'h2,
        CFS_OT_WAIT_EDGE = 3'h4
    } cfs_ot_t;

    // Timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int TXRX_SHORT_NS = 4000;
    localparam int RX_CLAMP_NS = 8000;
    localparam int TXRX_SHORT_CYC =
        (TXRX_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_CLAMP_CYC =
        (RX_CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_CNT_W = 8;

endpackage

/* File: src/cfs_sync.sv */
/*
 * Three-stage input synchroniser with agreement filter, one lane per bit.
 * Assumes asynchronous inputs; output changes only when stages two and
 * three agree.
 */
`timescale 1ns/100ps
`default_nettype none

module cfs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } cfs_sync_t;

    cfs_sync_t st_reg;
    cfs_sync_t st_next;

    generate
        if (W < 1) begin : g_chk
            $error("cfs_sync: width must be at least one");
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= {RST, RST, RST, RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.q;

endmodule

`default_nettype wire

/* File: src/cfs_filt.sv */
/*
 * Persistence filter: hit rises once cond has held for LIMIT cycles in a
 * row and stays while cond holds. Assumes cond is synchronous.
 */
`timescale 1ns/100ps
`default_nettype none

module cfs_filt #(
    parameter int CNT_W = 8,
    parameter int LIMIT = 80
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cond,
    output logic hit
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic hit;
    } cfs_filt_t;

    localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

    cfs_filt_t st_reg;
    cfs_filt_t st_next;

    generate
        if (LIMIT < 1 || LIMIT >= (1 << CNT_W)) begin : g_chk
            $error("cfs_filt: LIMIT does not fit the counter");
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        if (!cond) begin
            st_next.cnt = '0;
            st_next.hit = 1'b0;
        end else if (st_reg.cnt != LIM) begin
            st_next.cnt = st_reg.cnt + 1'b1;
            st_next.hit = (st_reg.cnt + 1'b1) == LIM;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hit = st_reg.hit;

endmodule

`default_nettype wire

/* File: dv/cfs_bus_model.sv */
/*
 * Far-side model: the bus wire and the host pin pads of the transceiver.
 * Assumes the testbench commands pad faults and foreign bus traffic.
 */
`timescale 1ns/100ps
`default_nettype none

module cfs_bus_model (
    input wire logic drv_en,
    input wire logic drv_dom,
    input wire logic rxd_pin,
    input wire logic txd_pin,
    input wire logic ext_dom,
    input wire logic short_txrx,
    input wire logic clamp_hi,
    output logic bus_rx_dom,
    output logic rxd_pin_sense
);
    // Dominant wins on the wire; another node may drive it at any time.
    assign bus_rx_dom = (drv_en & drv_dom) | ext_dom;
    // A pad short lets the host transmit level win on the receive pad.
    assign rxd_pin_sense = short_txrx ? txd_pin :
        (clamp_hi ? 1'b1 : rxd_pin);
endmodule
`default_nettype wire

/* File: dv/cfs_supervisor_tb_top.sv */
/*
 * Self-checking bench for the transceiver fault supervisor.
 * Assumes the plain register port and short filter times of 8 cycles.
 * The receive pin readback lags four cycles behind, so the filters must
 * be longer than that or normal traffic looks like a fault.
 */
`timescale 1ns/100ps
`default_nettype none

module cfs_supervisor_tb_top;
    import cfs_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic txd_pin, rxd_pin_sense, bus_rx_dom, bus_wake_det, overtemp_det;
    logic supply_uv, rxd_pin, drv_en, drv_dom, split_out, split_oe_n;
    logic transceiver_supply_en, int_n, ext_dom, short_txrx, clamp_hi;
    logic [5:0] bus_short_det;
    int n_mismatch, compares, cyc;

    cfs_supervisor #(.SHORT_CYC(8), .CLAMP_CYC(8)) cfs_supervisor_inst (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .txd_pin(txd_pin),
        .rxd_pin_sense(rxd_pin_sense), .bus_rx_dom(bus_rx_dom),
        .bus_wake_det(bus_wake_det), .overtemp_det(overtemp_det),
        .supply_uv(supply_uv), .bus_short_det(bus_short_det),
        .rxd_pin(rxd_pin), .drv_en(drv_en), .drv_dom(drv_dom),
        .split_out(split_out), .split_oe_n(split_oe_n),
        .transceiver_supply_en(transceiver_supply_en), .int_n(int_n));

    cfs_bus_model cfs_bus_model_inst (
        .drv_en(drv_en), .drv_dom(drv_dom), .rxd_pin(rxd_pin),
        .txd_pin(txd_pin), .ext_dom(ext_dom), .short_txrx(short_txrx),
        .clamp_hi(clamp_hi), .bus_rx_dom(bus_rx_dom),
        .rxd_pin_sense(rxd_pin_sense));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The limit is far above the roughly one thousand cycles the tests need.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic expect_rd(input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        check(d, exp);
    endtask

    // Waits a bounded time for the driver enable to reach a level.
    task automatic wait_drv(input logic exp);
        int i;
        for (i = 0; i < 40 && drv_en !== exp; i++) wait_cyc(1);
        check(drv_en, exp);
    endtask

    function automatic logic [7:0] ctrl_val(input logic [1:0] m);
        return 8'(m) | 8'h04;
    endfunction

    initial begin
        int i;
        logic [1:0] m;
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {txd_pin, bus_wake_det, overtemp_det, supply_uv} = 4'h8;
        {ext_dom, short_txrx, clamp_hi, bus_short_det} = '0;
        n_mismatch = 0;
        compares = 0;
        void'($urandom(32'h2c3d5066));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_cyc(1);
        check({int_n, drv_en, split_oe_n}, 8'h05);
        expect_rd(OFS_CTRL, CTRL_RST);
        expect_rd(OFS_MASK, 8'(MASK_RST));
        expect_rd(4'hf, 8'h00);
        for (i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(OFS_CTRL, ctrl_val(m));
            wait_cyc(8);
            check({split_out, split_oe_n}, 8'(m < 2) | 8'h02);
            check(drv_en, 8'(m == 3));
            check(transceiver_supply_en, 8'h01);
        end
        wr(OFS_CTRL, ctrl_val(CFS_MODE_RXONLY));
        for (i = 0; i < 20; i++) begin
            ext_dom <= 1'($urandom);
            wait_cyc(8);
            check({drv_en, rxd_pin}, {7'h00, ~ext_dom});
        end
        ext_dom <= 1'b0;
        wr(OFS_CTRL, ctrl_val(CFS_MODE_NORMAL));
        for (i = 0; i < 30; i++) begin
            txd_pin <= 1'($urandom);
            wait_cyc(10);
            check({drv_dom, rxd_pin}, {6'h00, ~txd_pin, txd_pin});
        end
        txd_pin <= 1'b1;
        rd(OFS_FLAGS);
        for (i = 0; i < NSHORT; i++) begin
            bus_short_det <= 6'h01 << i;
            wait_cyc(10);
            check(int_n, 8'h00);
            bus_short_det <= '0;
            wait_cyc(10);
            expect_rd(OFS_SHORTS, 8'h01 << i);
            expect_rd(OFS_CTRL, ctrl_val(CFS_MODE_NORMAL));
            check(drv_en, 8'h01);
            expect_rd(OFS_FLAGS, 8'h02);
            expect_rd(OFS_FLAGS, 8'h00);
            check(int_n, 8'h01);
        end
        wr(OFS_MASK, 8'h03);
        bus_short_det <= 6'h20;
        wait_cyc(10);
        check(int_n, 8'h01);
        bus_short_det <= '0;
        wait_cyc(10);
        rd(OFS_SHORTS);
        rd(OFS_FLAGS);
        wr(OFS_MASK, 8'h00);
        wr(OFS_CTRL, ctrl_val(CFS_MODE_RXONLY));
        short_txrx <= 1'b1;
        txd_pin <= 1'b0;
        wait_cyc(20);
        check(int_n, 8'h00);
        expect_rd(OFS_FLAGS, 8'h01);
        rd(OFS_LIVE);
        check(d[LIVE_TXRX_INH], 8'h01);
        wr(OFS_CTRL, 8'(CFS_MODE_RXONLY));
        wait_cyc(1);
        check(transceiver_supply_en, 8'h00);
        short_txrx <= 1'b0;
        txd_pin <= 1'b1;
        wr(OFS_CTRL, ctrl_val(CFS_MODE_NORMAL));
        wait_cyc(20);
        check(drv_en, 8'h00);
        wr(OFS_CMD, 8'h01);
        wait_drv(1'b1);
        rd(OFS_FLAGS);
        ext_dom <= 1'b1;
        clamp_hi <= 1'b1;
        wait_cyc(20);
        check(drv_en, 8'h00);
        expect_rd(OFS_FLAGS, 8'h04);
        wr(OFS_CMD, 8'h01);
        wait_cyc(10);
        check(drv_en, 8'h00);
        clamp_hi <= 1'b0;
        // A release only counts once the receive pin is seen dominant.
        wait_cyc(10);
        ext_dom <= 1'b0;
        wait_cyc(20);
        check(drv_en, 8'h00);
        wr(OFS_CMD, 8'h01);
        wait_drv(1'b1);
        rd(OFS_FLAGS);
        txd_pin <= 1'b0;
        overtemp_det <= 1'b1;
        wait_drv(1'b0);
        overtemp_det <= 1'b0;
        wait_cyc(30);
        check(drv_en, 8'h00);
        expect_rd(OFS_CTRL, ctrl_val(CFS_MODE_NORMAL));
        txd_pin <= 1'b1;
        wait_drv(1'b1);
        rd(OFS_FLAGS);
        check(d[FLG_OT], 8'h01);
        supply_uv <= 1'b1;
        wait_cyc(10);
        rd(OFS_LIVE);
        check({d[LIVE_UV], drv_en}, 8'h03);
        supply_uv <= 1'b0;
        wr(OFS_CTRL, ctrl_val(CFS_MODE_OFF));
        bus_wake_det <= 1'b1;
        wait_cyc(20);
        bus_wake_det <= 1'b0;
        rd(OFS_FLAGS);
        check(d[FLG_WAKE], 8'h00);
        check(int_n, 8'h01);
        wr(OFS_CTRL, ctrl_val(CFS_MODE_WAKE));
        bus_wake_det <= 1'b1;
        wait_cyc(20);
        bus_wake_det <= 1'b0;
        rd(OFS_FLAGS);
        check(d[FLG_WAKE], 8'h01);
        give_verdict();
    end
endmodule
`default_nettype wire
